/* File: common/dee_consts.vh */
// Purpose: constants for the data nvm erase/write controller
// Assumes: apb byte addresses, 20 MHz pclk
// Notes: times are in microseconds, counts derived from the clock rate
`ifndef DEE_CONSTS_VH
`define DEE_CONSTS_VH
`define DEE_CLK_MHZ 20
`define DEE_OFF_ADDR 12'h000
`define DEE_OFF_DATA 12'h004
`define DEE_OFF_CTRL 12'h008
`define DEE_OFF_IRQ 12'h00c
`define DEE_OFF_MEM 12'h010
`define DEE_CTRL_PTS 7
`define DEE_CTRL_WIPE_EN 6
`define DEE_CTRL_WIPE_GO 5
`define DEE_CTRL_MODE 4
`define DEE_CTRL_STORE_EN 3
`define DEE_CTRL_STORE_GO 2
`define DEE_IRQ_FLAG 0
`define DEE_IRQ_EN 1
`define DEE_IRQ_MF_FLAG 2
`define DEE_IRQ_MF_EN 3
`define DEE_IRQ_GIE 4
`define DEE_IRQ_STACK_FULL 5
`define DEE_T_ERASE0_US 3200
`define DEE_T_WRITE0_US 2200
`define DEE_T_ERASE1_US 3700
`define DEE_T_WRITE1_US 3000
`define DEE_CYC(us) ((us) * `DEE_CLK_MHZ)
`define DEE_PAGE_LAST 4'hf
`endif

/* File: rtl/dee_ctrl.v */
// Purpose: data nvm page erase, byte write and page write controller
// Assumes: apb slave on pclk, timer counts down once per pclk cycle
// Notes: 128 x 8 array held locally; reads of the array are direct
// Notes: the program timer is modelled on pclk here; a real one runs
//        from its own oscillator, so its done level is crossed by two
//        flops; flags and control bits wait for the crossed copy, the array does not
// What this block does
// - mode high plus erase start clears only the tagged bytes of one 16-byte page.
// - buffer emptied on reset and on wipe enable falling, not rising.
// - page erase dummy data writes advance low 4 address bits only.
// - erase timed by async timer; wipe start self-clears at end.
// - after page erase, wipe enable cleared and erased bytes read zero.
// - store start ignored unless store enable already high.
// - write timed by async timer; store start self-clears at end.
// - byte write first erases that byte, then programs it.
// - page write data writes fill buffer and advance low address.
// - once low address stopped at 0fh, further data writes reach data only, not the buffer.
// - buffer emptied on store enable falling, not rising.
// - store enable cleared by hardware after page write completes.
// - store enable cleared at power-on.
// - cycle end sets nvm flag and multi-function flag.
// - vector request only with all enables set and stack not full.
// - servicing clears mf flag and global enable; software clears nvm flag.
// - control bits 7 pts, 6 wipe en, 5 wipe go, 4 mode, 3 en, 2 go.
// - pts low 3.2ms erase 2.2ms write; high 3.7ms and 3.0ms.
`timescale 1ns/1ps
`include "dee_consts.vh"
module dee_ctrl #(
   parameter ERASE0_CYC = `DEE_CYC(`DEE_T_ERASE0_US),
   parameter WRITE0_CYC = `DEE_CYC(`DEE_T_WRITE0_US),
   parameter ERASE1_CYC = `DEE_CYC(`DEE_T_ERASE1_US),
   parameter WRITE1_CYC = `DEE_CYC(`DEE_T_WRITE1_US)
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire irq_service,
   output reg vector_req,
   output reg busy
);
   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   // idle: registers writable, start bits polled
   localparam ST_IDLE = 2'd0;
   // erase phase, page erase or the pre-erase of a byte write
   localparam ST_ERASE = 2'd1;
   // programming phase, byte or page
   localparam ST_WRITE = 2'd2;
   // timer ran out; waiting for the crossed done level
   localparam ST_DONE = 2'd3;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // array and buffer data are not reset: only the tags say what
   // is valid, which keeps the reset tree small

   reg [6:0] addr_reg;
   reg [7:0] data_reg;
   reg [7:0] ctrl_reg;
   reg nvm_flag_reg, nvm_en_reg, mf_flag_reg, mf_en_reg, gie_reg;
   reg stack_full_reg;
   reg [7:0] mem [0:127];
   reg [7:0] buf_data [0:15];
   reg [15:0] buf_tag;
   reg [1:0] state_reg;
   reg [17:0] tmr_reg;
   reg done_meta, done_sync;
   reg tmr_done;
   reg ph_reg;
   reg wipe_en_d, store_en_d;
   reg [6:0] op_addr;
   integer i;

   // ------------------------------------------------------------
   // decode and derived controls
   // ------------------------------------------------------------
   // writes land in the access cycle; the setup cycle only
   // prepares pready, read data and the error flag
   wire setup = psel & ~penable;
   wire wr_acc = psel & penable & pwrite;
   wire [31:0] wv = pwdata;
   wire page_mode = ctrl_reg[`DEE_CTRL_MODE];
   wire pts = ctrl_reg[`DEE_CTRL_PTS];
   wire at_edge = addr_reg[3:0] == `DEE_PAGE_LAST;
   wire wr_data = wr_acc && paddr == `DEE_OFF_DATA;
   wire wr_ctrl = wr_acc && paddr == `DEE_OFF_CTRL;
   wire wr_irq = wr_acc && paddr == `DEE_OFF_IRQ;
   // 18 bits cover the longest time at 20 MHz with room to spare
   wire [17:0] erase_len = pts ? ERASE1_CYC[17:0] : ERASE0_CYC[17:0];
   wire [17:0] write_len = pts ? WRITE1_CYC[17:0] : WRITE0_CYC[17:0];
   wire buf_clr = (wipe_en_d & ~ctrl_reg[`DEE_CTRL_WIPE_EN]) |
                  (store_en_d & ~ctrl_reg[`DEE_CTRL_STORE_EN]);
   // a tagged slot at the last address means the pointer already stopped
   wire page_full = at_edge & buf_tag[15];

   // ------------------------------------------------------------
   // apb slave: zero wait states, unmapped address gives pslverr except in 080h-0ffh
   // ------------------------------------------------------------
   // answer is fixed one cycle after setup, so pready needs no
   // decode of the access phase; reads of the array never stall
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && paddr != `DEE_OFF_ADDR &&
                    paddr != `DEE_OFF_DATA && paddr != `DEE_OFF_CTRL &&
                    paddr != `DEE_OFF_IRQ && paddr[11:7] != 5'h01 &&
                    paddr[11:9] != 3'h1;
         prdata <= 32'h0;
         if (setup && !pwrite) begin
            case (paddr)
               `DEE_OFF_ADDR: prdata <= {25'h0, addr_reg};
               `DEE_OFF_DATA: prdata <= {24'h0, data_reg};
               `DEE_OFF_CTRL: prdata <= {24'h0, ctrl_reg};
               `DEE_OFF_IRQ: prdata <= {26'h0, stack_full_reg, gie_reg,
                  mf_en_reg, mf_flag_reg, nvm_en_reg, nvm_flag_reg};
               default: begin
                  // array window: word index = byte address
                  if (paddr[11:9] == 3'h1)
                     prdata <= {24'h0, mem[paddr[8:2]]};
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // cycle end from the program timer domain
   // ------------------------------------------------------------
   // done_meta is read by nothing but done_sync; a level, not a
   // pulse, is crossed so no event is lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_meta <= 1'b0;
         done_sync <= 1'b0;
      end else begin
         done_meta <= tmr_done;
         done_sync <= done_meta;
      end
   end

   // ------------------------------------------------------------
   // registers, buffer and sequencer
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= 7'h0;
         data_reg <= 8'h0;
         ctrl_reg <= 8'h0;
         nvm_flag_reg <= 1'b0;
         nvm_en_reg <= 1'b0;
         mf_flag_reg <= 1'b0;
         mf_en_reg <= 1'b0;
         gie_reg <= 1'b0;
         stack_full_reg <= 1'b0;
         buf_tag <= 16'h0;
         state_reg <= ST_IDLE;
         tmr_reg <= 18'h0;
         tmr_done <= 1'b0;
         ph_reg <= 1'b0;
         wipe_en_d <= 1'b0;
         store_en_d <= 1'b0;
         op_addr <= 7'h0;
         vector_req <= 1'b0;
         busy <= 1'b0;
      end else begin
         wipe_en_d <= ctrl_reg[`DEE_CTRL_WIPE_EN];
         store_en_d <= ctrl_reg[`DEE_CTRL_STORE_EN];
         if (buf_clr)
            buf_tag <= 16'h0;
         // control is frozen during a cycle so a stray write cannot
         // change mode or timing under the running operation
         if (wr_ctrl && state_reg == ST_IDLE) begin
            ctrl_reg[7:3] <= wv[7:3];
            // start bits only take if their enable was already high
            ctrl_reg[`DEE_CTRL_STORE_GO] <= wv[`DEE_CTRL_STORE_GO] &
               ctrl_reg[`DEE_CTRL_STORE_EN];
            ctrl_reg[`DEE_CTRL_WIPE_GO] <= wv[`DEE_CTRL_WIPE_GO] &
               ctrl_reg[`DEE_CTRL_WIPE_EN];
            ctrl_reg[1:0] <= 2'b00;
         end
         // a new page start leaves the tags alone
         if (wr_acc && paddr == `DEE_OFF_ADDR && state_reg == ST_IDLE)
            addr_reg <= wv[6:0];
         // in page mode the data write both fills a slot and tags
         // it; an erase only looks at the tags
         if (wr_data && state_reg == ST_IDLE) begin
            data_reg <= wv[7:0];
            if (page_mode && !page_full) begin
               buf_data[addr_reg[3:0]] <= wv[7:0];
               buf_tag[addr_reg[3:0]] <= 1'b1;
               if (!at_edge)
                  addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
            end
         end
         // flag set wins over software clear
         if (wr_irq) begin
            nvm_flag_reg <= wv[`DEE_IRQ_FLAG];
            nvm_en_reg <= wv[`DEE_IRQ_EN];
            mf_flag_reg <= wv[`DEE_IRQ_MF_FLAG];
            mf_en_reg <= wv[`DEE_IRQ_MF_EN];
            gie_reg <= wv[`DEE_IRQ_GIE];
            stack_full_reg <= wv[`DEE_IRQ_STACK_FULL];
         end
         if (irq_service) begin
            mf_flag_reg <= 1'b0;
            gie_reg <= 1'b0;
         end
         vector_req <= nvm_flag_reg & nvm_en_reg & mf_flag_reg & mf_en_reg &
                       gie_reg & ~stack_full_reg & ~irq_service;
         busy <= state_reg != ST_IDLE;
         case (state_reg)
            ST_IDLE: begin
               // erase start has priority; both can be accepted together
               // when both enables were already high before the start write
               tmr_done <= 1'b0;
               if (ctrl_reg[`DEE_CTRL_WIPE_GO]) begin
                  tmr_reg <= erase_len;
                  state_reg <= ST_ERASE;
               end else if (ctrl_reg[`DEE_CTRL_STORE_GO]) begin
                  tmr_reg <= erase_len;
                  ph_reg <= 1'b0;
                  op_addr <= addr_reg;
                  state_reg <= page_mode ? ST_WRITE : ST_ERASE;
                  if (page_mode)
                     tmr_reg <= write_len;
               end
            end
            ST_ERASE: begin
               // a byte write passes through here first and then
               // reloads the timer with the write time
               if (tmr_reg > 18'h1)
                  tmr_reg <= tmr_reg - 18'h1;
               else if (ctrl_reg[`DEE_CTRL_WIPE_GO]) begin
                  for (i = 0; i < 16; i = i + 1)
                     if (buf_tag[i])
                        mem[{addr_reg[6:4], i[3:0]}] <= 8'h00;
                  tmr_done <= 1'b1;
                  state_reg <= ST_DONE;
               end else begin
                  mem[op_addr] <= 8'h00;
                  tmr_reg <= write_len;
                  state_reg <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               // the array changes only at the end of the time, so a cut page
               // write leaves the old content in place; a byte write cut here leaves 00h
               if (tmr_reg > 18'h1)
                  tmr_reg <= tmr_reg - 18'h1;
               else begin
                  if (page_mode) begin
                     for (i = 0; i < 16; i = i + 1)
                        if (buf_tag[i])
                           mem[{addr_reg[6:4], i[3:0]}] <= buf_data[i];
                  end else
                     mem[op_addr] <= data_reg;
                  tmr_done <= 1'b1;
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE: begin
               // status, enables and flags all move on one edge so
               // software never sees a half-finished state
               if (done_sync) begin
                  // hardware set beats a same-cycle software clear
                  nvm_flag_reg <= 1'b1;
                  mf_flag_reg <= 1'b1;
                  ctrl_reg[`DEE_CTRL_WIPE_GO] <= 1'b0;
                  ctrl_reg[`DEE_CTRL_STORE_GO] <= 1'b0;
                  if (ctrl_reg[`DEE_CTRL_WIPE_GO])
                     ctrl_reg[`DEE_CTRL_WIPE_EN] <= 1'b0;
                  else
                     ctrl_reg[`DEE_CTRL_STORE_EN] <= 1'b0;
                  tmr_done <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule

/* File: sim/dee_ctrl_properties.sv */
// Purpose: port-level checks for dee_ctrl
// Assumes: apb slave on pclk, one clock domain
// Notes: busy bound allows a few cycles of sync slack
`timescale 1ns/1ps
module dee_ctrl_properties #(
   parameter ERASE1_CYC = 74000,
   parameter WRITE1_CYC = 60000
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire irq_service,
   input wire vector_req,
   input wire busy
);
reg [31:0] busy_cnt;
reg [3:0] since_go;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      busy_cnt <= 32'h0;
      since_go <= 4'hf;
   end else begin
      busy_cnt <= busy ? busy_cnt + 32'h1 : 32'h0;
      if (pready && pwrite && paddr == 12'h008)
         since_go <= 4'h0;
      else if (since_go != 4'hf)
         since_go <= since_go + 4'h1;
   end
end
// ----------------------------------------
// checks
// ----------------------------------------
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
property p_rdy; psel && !penable |=> pready; endproperty
a_rdy: assert property (p_rdy) else $error("no ready after setup");
property p_acc; pready |-> psel && penable; endproperty
a_acc: assert property (p_acc) else $error("ready outside access");
property p_one; pready |=> !pready; endproperty
a_one: assert property (p_one) else $error("ready held");
property p_err; pslverr |-> pready; endproperty
a_err: assert property (p_err) else $error("error without ready");
property p_hi; pready && !pwrite && paddr < 12'h010 |->
   prdata[31:8] == 24'h0; endproperty
a_hi: assert property (p_hi) else $error("upper bits set");
property p_svc; irq_service |-> ##[1:2] !vector_req; endproperty
a_svc: assert property (p_svc) else $error("vector kept");
property p_len; busy_cnt <= ERASE1_CYC + WRITE1_CYC + 16; endproperty
a_len: assert property (p_len) else $error("busy too long");
property p_why; $rose(busy) |-> since_go <= 4'h4; endproperty
a_why: assert property (p_why) else $error("busy uncaused");
property p_rst; $rose(presetn) |-> !busy && !vector_req; endproperty
a_rst: assert property (p_rst) else $error("busy at reset");
c_busy: cover property ($fell(busy));
c_vec: cover property (vector_req);
c_err: cover property (pslverr);
endmodule
bind dee_ctrl dee_ctrl_properties #(.ERASE1_CYC(ERASE1_CYC),
   .WRITE1_CYC(WRITE1_CYC)) dee_props_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_service(irq_service), .vector_req(vector_req), .busy(busy));

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for dee_ctrl
// Assumes: short cycle counts set through parameters
// Notes: every wait is bounded
`timescale 1ns/1ps
`include "dee_consts.vh"
module tb_top;
localparam E0 = 20;
localparam W0 = 12;
localparam E1 = 30;
localparam W1 = 16;
localparam [11:0] CT = `DEE_OFF_CTRL;
localparam [11:0] AD = `DEE_OFF_ADDR;
localparam [11:0] DT = `DEE_OFF_DATA;
localparam [11:0] IQ = `DEE_OFF_IRQ;
reg pclk, presetn, psel, penable, pwrite, irq_service, rerr;
reg [11:0] paddr;
reg [31:0] pwdata, rdata;
wire [31:0] prdata;
wire pready, pslverr, vector_req, busy;
integer miscompares, checks, cyc, i;
dee_ctrl #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1),
   .WRITE1_CYC(W1)) dee_ctrl_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_service(irq_service), .vector_req(vector_req), .busy(busy));
initial begin
   pclk = 1'b0;
   forever #25 pclk = ~pclk;
end
function [11:0] ma(input [6:0] n);
   ma = 12'h200 + {3'h0, n, 2'h0};
endfunction
task close_out;
begin
   $display("checks %0d miscompares %0d", checks, miscompares);
   if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
end
endtask
task chk(input string nm, input [31:0] s, input [31:0] e);
begin
   checks++;
   if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
   end
end
endtask
// ----------------------------------------
// apb master: read data taken at the ready edge
// ----------------------------------------
task ap(input wr, input [11:0] a, input [31:0] d);
integer n;
begin
   psel <= 1'b1;
   pwrite <= wr;
   paddr <= a;
   pwdata <= d;
   @(posedge pclk);
   penable <= 1'b1;
   n = 0;
   @(posedge pclk);
   while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
   end
   if (n == 20) begin
      miscompares++;
      close_out;
   end
   // taken at the ready edge, released right after it
   rdata = prdata;
   rerr = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
   @(posedge pclk);
end
endtask
task r(input [11:0] a, input [31:0] e, input string nm);
begin
   ap(1'b0, a, 32'h0);
   chk(nm, rdata, e);
end
endtask
// enable then start on back-to-back writes, then time busy
task go(input [31:0] en, input [31:0] gb);
integer k;
begin
   ap(1'b1, CT, en);
   ap(1'b1, CT, en | gb);
   cyc = 0;
   for (k = 0; k < 400 && (busy === 1'b1 || (cyc == 0 && k < 10)); k++)
   begin
      @(negedge pclk);
      if (busy === 1'b1)
         cyc++;
   end
   if (busy !== 1'b0) begin
      miscompares++;
      close_out;
   end
   @(posedge pclk);
end
endtask
initial begin
   {psel, penable, pwrite, irq_service, presetn} = 5'h0;
   paddr = 12'h0;
   pwdata = 32'h0;
   miscompares = 0;
   checks = 0;
   repeat (6) @(posedge pclk);
   presetn <= 1'b1;
   @(posedge pclk);
   r(CT, 32'h0, "ctrl");
   ap(1'b0, 12'h100, 32'h0);
   chk("slverr", rerr, 1);
   ap(1'b1, CT, 32'h24);
   r(CT, 32'h0, "ctrl");
   $display("test reset and refusal done");
   ap(1'b1, AD, 32'h5);
   ap(1'b1, DT, 32'ha5);
   go(32'h08, 32'h04);
   chk("blen0", cyc >= E0 + W0, 1);
   r(ma(7'h5), 32'ha5, "mem");
   r(CT, 32'h0, "ctrl");
   r(IQ, 32'h5, "irq");
   ap(1'b1, AD, 32'h6);
   ap(1'b1, DT, 32'h3c);
   go(32'h88, 32'h04);
   chk("blen1", cyc >= E1 + W1, 1);
   r(ma(7'h6), 32'h3c, "mem");
   $display("test byte write done");
   for (i = 0; i < 3; i++) begin
      ap(1'b1, IQ, i == 1 ? 32'h3f : 32'h1f);
      @(negedge pclk);
      chk("vector", vector_req, i != 1);
      @(posedge pclk);
   end
   irq_service <= 1'b1;
   @(posedge pclk);
   irq_service <= 1'b0;
   @(posedge pclk);
   r(IQ, 32'h0b, "irq");
   $display("test interrupt done");
   ap(1'b1, CT, 32'h10);
   ap(1'b1, AD, 32'h20);
   for (i = 0; i < 17; i++)
      ap(1'b1, DT, i + 1);
   r(AD, 32'h2f, "addr");
   go(32'h18, 32'h04);
   r(CT, 32'h10, "ctrl");
   for (i = 0; i < 16; i++)
      r(ma(7'h20 + i[6:0]), i + 1, "mem");
   $display("test page write done");
   ap(1'b1, AD, 32'h20);
   for (i = 0; i < 4; i++)
      ap(1'b1, DT, 32'hff);
   go(32'h50, 32'h20);
   chk("elen", cyc >= E0, 1);
   r(CT, 32'h10, "ctrl");
   for (i = 0; i < 5; i++)
      r(ma(7'h20 + i[6:0]), i < 4 ? 0 : 5, "mem");
   $display("test page erase done");
   ap(1'b1, AD, 32'h25);
   ap(1'b1, DT, 32'h77);
   ap(1'b1, CT, 32'h18);
   ap(1'b1, CT, 32'h10);
   go(32'h18, 32'h04);
   r(ma(7'h25), 32'h6, "mem");
   ap(1'b1, AD, 32'h24);
   ap(1'b1, DT, 32'h0);
   ap(1'b1, CT, 32'h50);
   ap(1'b1, CT, 32'h10);
   go(32'h50, 32'h20);
   r(ma(7'h24), 32'h5, "mem");
   $display("test buffer clear done");
   close_out;
end
endmodule
